/* rtl/aopc_top.sv */
// Overflow detection, interrupt gating and core power control of a
// 12-bit converter's first control register, with an AHB-Lite slave.
// Assumes one 200 MHz clock; result-write and read strobes and the
// global interrupt enable come from logic on the same clock, the
// external trigger from a pin.
`include "aopc_consts.svh"

module aopc_top
    import aopc_pkg::*;
#(
    parameter int SLOTS = 16,
    parameter int CONV_CYCLES = `AOPC_CONV_CYCLES
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Converter events
    input wire logic ext_trigger,
    input wire logic [3:0] result_slot,
    input wire logic result_write,
    input wire logic result_read,
    input wire logic global_irq_enable,
    // Converter outputs
    output logic core_power,
    output logic reference_power,
    output logic conv_busy,
    output logic timing_overflow_irq,
    output logic result_overflow_irq
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    aopc_word_t ctl0_r, ctl0_nxt;
    aopc_state_e state_r, state_nxt;
    logic [7:0] cnt_r, cnt_nxt;
    logic [SLOTS-1:0] unread_r, unread_nxt;
    logic tov_r, tov_nxt;
    logic ov_r, ov_nxt;
    logic trig_q_r;
    logic trig_s;
    logic wr_pend_r, wr_pend_nxt;
    logic rd_pend_r, rd_pend_nxt;
    logic [`AOPC_ADDR_W-1:0] addr_r, addr_nxt;
    logic [31:0] rdata_nxt;
    logic start_req, clear_tov, clear_ov, cur_unread;
    logic [SLOTS-1:0] slot_hot;

    // Pin trigger through two flops before use
    aopc_sync #(.W(1)) u_sync (
        .mclk(mclk),
        .rstn(rstn),
        .din(ext_trigger),
        .dout(trig_s)
    );

    // ------------------------------------------------------------
    // AHB-Lite slave: zero wait states, always OKAY
    // ------------------------------------------------------------
    always_comb begin
        wr_pend_nxt = 1'b0;
        rd_pend_nxt = 1'b0;
        addr_nxt = addr_r;
        if (hsel && hready && htrans[1]) begin
            wr_pend_nxt = hwrite;
            rd_pend_nxt = !hwrite;
            addr_nxt = haddr[`AOPC_ADDR_W-1:0];
        end
    end

    // Read data registered in the address phase so hrdata is a flop
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        if (hsel && hready && htrans[1] && !hwrite) begin
            if (haddr[`AOPC_ADDR_W-1:0] == `AOPC_CTL0_ADDR)
                rdata_nxt = {16'h0000, ctl0_nxt};
            else if (haddr[`AOPC_ADDR_W-1:0] == `AOPC_STAT_ADDR) begin
                rdata_nxt[`AOPC_ST_TOV_BIT] = tov_nxt;
                rdata_nxt[`AOPC_ST_OV_BIT] = ov_nxt;
                rdata_nxt[`AOPC_ST_BUSY_BIT] = (state_nxt == AOPC_CONV);
            end
        end
    end

    // Status flags cleared by writing one in the data phase
    assign clear_tov = wr_pend_r && (addr_r == `AOPC_STAT_ADDR)
        && hwdata[`AOPC_ST_TOV_BIT];
    assign clear_ov = wr_pend_r && (addr_r == `AOPC_STAT_ADDR)
        && hwdata[`AOPC_ST_OV_BIT];

    // ------------------------------------------------------------
    // Control register and conversion sequencer
    // ------------------------------------------------------------
    always_comb begin
        ctl0_nxt = ctl0_r;
        if (wr_pend_r && addr_r == `AOPC_CTL0_ADDR)
            ctl0_nxt = hwdata[15:0] & `AOPC_CTL0_WMASK;
        // Start request: software bit or rising pin edge
        start_req = (ctl0_r[`AOPC_START_BIT] || (trig_s && !trig_q_r))
            && ctl0_r[`AOPC_ENC_BIT];
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        tov_nxt = tov_r;
        unique case (state_r)
            AOPC_IDLE: begin
                // Core off refuses any start
                if (start_req && ctl0_r[`AOPC_ON_BIT]) begin
                    state_nxt = AOPC_CONV;
                    cnt_nxt = 8'(CONV_CYCLES - 1);
                end
            end
            AOPC_CONV: begin
                if (start_req)
                    tov_nxt = 1'b1;
                if (!ctl0_r[`AOPC_ON_BIT] || cnt_r == 8'h00)
                    state_nxt = AOPC_IDLE;
                else
                    cnt_nxt = cnt_r - 8'h01;
            end
            default: state_nxt = AOPC_IDLE;
        endcase
        // Start bit self-clears only once taken, on the step from idle into conversion
        if (state_r == AOPC_IDLE && state_nxt == AOPC_CONV)
            ctl0_nxt[`AOPC_START_BIT] = 1'b0;
        // Set wins over a same-cycle clear
        if (clear_tov && !(state_r == AOPC_CONV && start_req))
            tov_nxt = 1'b0;
    end

    // ------------------------------------------------------------
    // Unread tracking per result slot
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < SLOTS; gi++) begin : g_slot
            assign slot_hot[gi] = (result_slot == 4'(gi));
            always_comb begin
                unread_nxt[gi] = unread_r[gi];
                if (result_read && slot_hot[gi])
                    unread_nxt[gi] = 1'b0;
                // Write after read in same cycle leaves it unread
                if (result_write && slot_hot[gi])
                    unread_nxt[gi] = 1'b1;
            end
        end
    endgenerate

    assign cur_unread = |(unread_r & slot_hot);

    // Result overflow flag, set beats clear
    always_comb begin
        ov_nxt = ov_r;
        if (clear_ov)
            ov_nxt = 1'b0;
        if (result_write && cur_unread && !result_read)
            ov_nxt = 1'b1;
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            ctl0_r <= `AOPC_CTL0_RST;
            state_r <= AOPC_IDLE;
            cnt_r <= 8'h00;
            unread_r <= '0;
            tov_r <= 1'b0;
            ov_r <= 1'b0;
            trig_q_r <= 1'b0;
            wr_pend_r <= 1'b0;
            rd_pend_r <= 1'b0;
            addr_r <= '0;
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            core_power <= 1'b0;
            reference_power <= 1'b0;
            conv_busy <= 1'b0;
            timing_overflow_irq <= 1'b0;
            result_overflow_irq <= 1'b0;
        end else begin
            ctl0_r <= ctl0_nxt;
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            unread_r <= unread_nxt;
            tov_r <= tov_nxt;
            ov_r <= ov_nxt;
            trig_q_r <= trig_s;
            wr_pend_r <= wr_pend_nxt;
            rd_pend_r <= rd_pend_nxt;
            addr_r <= addr_nxt;
            hrdata <= rdata_nxt;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            core_power <= ctl0_nxt[`AOPC_ON_BIT];
            reference_power <= ctl0_nxt[`AOPC_REFERENCE_POWER_ENABLE_BIT];
            conv_busy <= (state_nxt == AOPC_CONV);
            timing_overflow_irq <= tov_nxt
                && ctl0_nxt[`AOPC_TOVIE_BIT];
            result_overflow_irq <= ov_nxt && ctl0_nxt[`AOPC_OVIE_BIT]
                && global_irq_enable;
        end
    end
endmodule

/* rtl/aopc_consts.svh */
// Offsets, field positions and reset values of the converter control block.
// Assumes inclusion by bare name from rtl/ files only.
`ifndef AOPC_CONSTS_SVH
`define AOPC_CONSTS_SVH

// ------------------------------------------------------------
// Register map (byte addresses on the AHB-Lite bus)
// ------------------------------------------------------------
`define AOPC_CTL0_ADDR 12'h1a0
`define AOPC_STAT_ADDR 12'h1a4
`define AOPC_ADDR_W 12

// ------------------------------------------------------------
// Control register field positions
// ------------------------------------------------------------
`define AOPC_START_BIT 0
`define AOPC_ENC_BIT 1
`define AOPC_TOVIE_BIT 2
`define AOPC_OVIE_BIT 3
`define AOPC_ON_BIT 4
`define AOPC_REFERENCE_POWER_ENABLE_BIT 5
`define AOPC_CTL0_RST 16'h0000
`define AOPC_CTL0_WMASK 16'hffff

// ------------------------------------------------------------
// Status register field positions
// ------------------------------------------------------------
`define AOPC_ST_TOV_BIT 0
`define AOPC_ST_OV_BIT 1
`define AOPC_ST_BUSY_BIT 2

// ------------------------------------------------------------
// Conversion length in converter clock cycles
// ------------------------------------------------------------
`define AOPC_CONV_CYCLES 13

`endif

/* rtl/aopc_pkg.sv */
// Types shared by the converter control block.
// Assumes nothing beyond a SystemVerilog compiler.
package aopc_pkg;
    typedef enum logic [1:0] {
        AOPC_IDLE,
        AOPC_CONV
    } aopc_state_e;
    typedef logic [15:0] aopc_word_t;
endpackage

/* rtl/aopc_sync.sv */
// Two-stage synchroniser for a bus of external level inputs.
// Assumes mclk domain; inputs are asynchronous.
module aopc_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // Data
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] meta_r;
    logic [W-1:0] meta_nxt;
    logic [W-1:0] dout_nxt;

    // First stage only feeds the second
    always_comb begin
        meta_nxt = din;
        dout_nxt = meta_r;
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            meta_r <= '0;
            dout <= '0;
        end else begin
            meta_r <= meta_nxt;
            dout <= dout_nxt;
        end
    end
endmodule

/* bench/aopc_asserts.sv */
// Port checker for the converter control block.
// Assumes it is bound into aopc_top and sees only its ports.
module aopc_asserts #(
    parameter int CONV_CYCLES = 13
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // Watched ports
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic result_write,
    input wire logic global_irq_enable,
    input wire logic core_power,
    input wire logic conv_busy,
    input wire logic timing_overflow_irq,
    input wire logic result_overflow_irq
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);
    // --------
    // Busy length counter, too long for a plain repetition
    // --------
    logic [7:0] busy_cnt_r;
    logic [7:0] busy_cnt_nxt;
    always_comb busy_cnt_nxt = conv_busy ? busy_cnt_r + 8'h01 : 8'h00;
    // Counter clears in reset so a new run starts from zero
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) busy_cnt_r <= 8'h00;
        else busy_cnt_r <= busy_cnt_nxt;
    end
    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus slave not ready or erroring");
    a_conv_length: assert property ($fell(conv_busy) && core_power |->
        busy_cnt_r == 8'(CONV_CYCLES)) else $error("busy length wrong");
    a_start_powered: assert property (
        $rose(conv_busy) |-> core_power)
        else $error("conversion started unpowered");
    a_off_idle: assert property (!core_power [*2] |-> !conv_busy)
        else $error("busy while core off");
    a_tov_cause: assert property ($rose(timing_overflow_irq) |->
        $past(conv_busy) || $past(conv_busy, 2))
        else $error("stray timing irq");
    a_ovf_cause: assert property ($rose(result_overflow_irq) &&
        $past(global_irq_enable, 3) |-> $past(result_write) ||
        $past(result_write, 2) || $past(result_write, 3))
        else $error("stray result irq");
    a_ovf_global: assert property (result_overflow_irq |->
        $past(global_irq_enable)) else $error("result irq without global");
    c_busy: cover property ($rose(conv_busy));
    c_tov: cover property ($rose(timing_overflow_irq));
    c_ovf: cover property ($rose(result_overflow_irq));
endmodule

bind aopc_top aopc_asserts #(.CONV_CYCLES(CONV_CYCLES)) u_chk (
    .mclk(mclk),
    .rstn(rstn),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .result_write(result_write),
    .global_irq_enable(global_irq_enable),
    .core_power(core_power),
    .conv_busy(conv_busy),
    .timing_overflow_irq(timing_overflow_irq),
    .result_overflow_irq(result_overflow_irq)
);

/* bench/aopc_top_tb.sv */
// Self-checking bench for the converter control block.
// Assumes default parameters and a zero-wait AHB-Lite slave.
module aopc_top_tb;
    import aopc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'h0, rstn = 1'h0, hsel = 1'h0, hwrite = 1'h0;
    logic ext_trigger = 1'h0, result_write = 1'h0, result_read = 1'h0;
    logic global_irq_enable = 1'h0, hready, hreadyout, hresp;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic [31:0] seed = 32'heae3e2e7, ctl;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h0;
    logic [3:0] result_slot = 4'h0;
    logic core_power, reference_power, conv_busy;
    logic timing_overflow_irq, result_overflow_irq;
    int fail_count = 0, comparisons = 0, ov, i, m, k;
    int unr[16];
    assign hready = hreadyout;
    always #2.5 mclk = ~mclk;
    aopc_top u_dut (
        .mclk(mclk),
        .rstn(rstn),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hwdata(hwdata),
        .hready(hready),
        .hrdata(hrdata),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .ext_trigger(ext_trigger),
        .result_slot(result_slot),
        .result_write(result_write),
        .result_read(result_read),
        .global_irq_enable(global_irq_enable),
        .core_power(core_power),
        .reference_power(reference_power),
        .conv_busy(conv_busy),
        .timing_overflow_irq(timing_overflow_irq),
        .result_overflow_irq(result_overflow_irq)
    );
    // --------
    // Helpers
    // --------
    function logic [31:0] lf(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            fail_count++;
            $display("wrong value at %0t: got %h want %h", $time, g, e);
        end
    endtask
    // One single AHB transfer; read data kept in rd
    task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'h1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        hsize <= 3'h2;
        @(posedge mclk);
        while (hready !== 1'h1) @(posedge mclk);
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge mclk);
        while (hready !== 1'h1) @(posedge mclk);
        rd = hrdata;
    endtask
    // Spare edge after each pulse so strobes never double up
    task ev(input logic w, input logic [3:0] n);
        result_slot <= n;
        result_write <= w;
        result_read <= !w;
        @(posedge mclk);
        result_write <= 1'h0;
        result_read <= 1'h0;
        @(posedge mclk);
        if (w && unr[n] != 0) ov = 1;
        unr[n] = w;
    endtask
    task close_out;
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // Watchdog, far beyond the few hundred cycles needed
    initial begin
        #25000;
        fail_count++;
        close_out;
    end
    // --------
    // Scenarios
    // --------
    initial begin
        repeat (10) @(posedge mclk);
        rstn <= 1'h1;
        @(posedge mclk);
        bus(1'h0, 32'h1a0, 32'h0);
        chk(rd, 32'h0);
        chk(hreadyout, 1'h1);
        chk(hresp, 1'h0);
        // Random control words, start bit kept clear
        for (k = 0; k < 4; k++) begin
            seed = lf(seed);
            bus(1'h1, 32'h1a0, seed & 32'hfffffffe);
            ctl = seed & 32'hfffe;
            bus(1'h0, 32'h1a0, 32'h0);
            chk(rd, ctl);
            chk({reference_power, core_power}, ctl[5:4]);
        end
        bus(1'h1, 32'h1a8, seed);
        bus(1'h0, 32'h1a8, 32'h0);
        chk(rd, 32'h0);
        // Overflow by software, by pin, and with its enable off
        for (m = 0; m < 3; m++) begin
            ctl = (m == 2) ? 32'h1a : 32'h1e;
            bus(1'h1, 32'h1a0, ctl);
            bus(1'h1, 32'h1a0, ctl | 32'h1);
            repeat (2) @(posedge mclk);
            chk(conv_busy, 1'h1);
            if (m == 1) begin
                ext_trigger <= 1'h1;
                repeat (4) @(posedge mclk);
                ext_trigger <= 1'h0;
            end else bus(1'h1, 32'h1a0, ctl | 32'h1);
            repeat (3) @(posedge mclk);
            chk(timing_overflow_irq, m != 2);
            bus(1'h0, 32'h1a4, 32'h0);
            chk(rd & 32'h3, 32'h1);
            bus(1'h1, 32'h1a0, ctl);
            for (i = 0; i < 100 && conv_busy !== 1'h0; i++) @(posedge mclk);
            bus(1'h1, 32'h1a4, 32'h3);
            // Clear lands on the edge just taken; look one edge later
            @(posedge mclk);
            chk(timing_overflow_irq, 1'h0);
        end
        // Overwrite table: enable bit, global enable, read between
        for (k = 0; k < 4; k++) begin
            ctl = (k == 2) ? 32'h10 : 32'h18;
            bus(1'h1, 32'h1a0, ctl);
            global_irq_enable <= (k != 0);
            seed = lf(seed);
            ov = 0;
            ev(1'h0, seed[3:0]);
            ev(1'h1, seed[3:0]);
            if (k == 3) ev(1'h0, seed[3:0]);
            ev(1'h1, seed[3:0]);
            repeat (2) @(posedge mclk);
            chk(result_overflow_irq, ov && ctl[3] && k);
            bus(1'h0, 32'h1a4, 32'h0);
            chk(rd & 32'h3, ov << 1);
            bus(1'h1, 32'h1a4, 32'h3);
        end
        // Start refused unpowered; power off aborts a conversion
        bus(1'h1, 32'h1a0, 32'h3);
        repeat (4) @(posedge mclk);
        chk({core_power, conv_busy}, 2'h0);
        bus(1'h1, 32'h1a0, 32'h12);
        bus(1'h1, 32'h1a0, 32'h13);
        repeat (2) @(posedge mclk);
        chk(conv_busy, 1'h1);
        bus(1'h1, 32'h1a0, 32'h2);
        repeat (2) @(posedge mclk);
        chk({core_power, conv_busy}, 2'h0);
        close_out;
    end
endmodule
